//--- rtl/ccr_pkg.sv
// Constants shared by the core clock and rate control block.
// Assumes a 20 MHz system clock and byte-wide registers on a 16-bit address.
package ccr_pkg;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [15:0] ADDR_CLOCK_CONTROL     = 16'h4000;
   localparam logic [15:0] ADDR_PLL_CONTROL       = 16'h4002;
   localparam logic [15:0] ADDR_CONVERTER_CTRL0   = 16'h4017;
   localparam logic [15:0] ADDR_POWER_ENABLE_A    = 16'h4080;
   localparam logic [15:0] ADDR_POWER_ENABLE_B    = 16'h4081;
   localparam logic [15:0] ADDR_ENGINE_FRAME_RATE = 16'h40eb;
   localparam logic [15:0] ADDR_SERIAL_PORT_RATE  = 16'h40f8;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int BIT_CORE_EN     = 0;
   localparam int BIT_RATE_LO     = 1;
   localparam int BIT_RATE_HI     = 2;
   localparam int BIT_SRC_PLL     = 3;
   localparam int BIT_ADC_OSR64   = 3;
   localparam int BIT_DAC_OSR64   = 4;
   localparam int BIT_MEM_CTRL    = 6;
   localparam int BIT_ENGINE      = 0;
   localparam int BIT_ADC_PWR     = 0;
   localparam int BIT_DAC_PWR     = 1;
   localparam int BIT_PLL_PWR     = 2;
   localparam int BIT_LOCK_STATUS = 1;

   // ----------------------------------------------------------------------
   // Reset values and divider codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [1:0] DIV_BY_FOUR     = 2'h3;
   localparam int         CORE_PER_FS     = 256;
   localparam int         HALF_FS_TICKS   = CORE_PER_FS / 2;
   localparam int         RATE_CNT_W      = 11;

   // Base rate scaling in half-period units, reserved codes fall back to /1
   function automatic logic [3:0] ccr_half_units(input logic [3:0] code);
      logic [3:0] h;
      h = 4'h2;
      case (code)
         4'h0:    h = 4'h2;
         4'h1:    h = 4'hc;
         4'h2:    h = 4'h8;
         4'h3:    h = 4'h6;
         4'h4:    h = 4'h4;
         4'h5:    h = 4'h3;
         4'h6:    h = 4'h1;
         default: h = 4'h2;
      endcase
      return h;
   endfunction : ccr_half_units

endpackage : ccr_pkg

//--- rtl/ccr_rate_if.sv
// Interface between the clock controller and one sample rate divider.
// Assumes both ends run on the same system clock.
interface ccr_rate_if;
   logic       clear;
   logic       core_tick;
   logic [3:0] code;
   logic       rate_tick;

   modport ctrl (output clear, output core_tick, output code, input rate_tick);
   modport div  (input clear, input core_tick, input code, output rate_tick);
endinterface : ccr_rate_if

//--- rtl/ccr_rate_div.sv
// Sample rate divider: one rate tick per programmed number of core ticks.
// Assumes core_tick pulses at most every second system clock.
module ccr_rate_div (
   // System
   input wire logic clk,
   // Link to the controller
   ccr_rate_if.div  rif
);

   localparam int RATE_CNT_W_L = ccr_pkg::RATE_CNT_W;
   logic [RATE_CNT_W_L-1:0] cnt_reg;
   logic [RATE_CNT_W_L-1:0] limit;
   logic                    tick_reg;

   // Period in core ticks, reserved codes land on /1
   assign limit = RATE_CNT_W_L'(ccr_pkg::ccr_half_units(rif.code) * ccr_pkg::HALF_FS_TICKS);

   // Core tick counter and rate pulse
   always_ff @(posedge clk) begin
      if (rif.clear) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (rif.core_tick) begin
         if (cnt_reg >= limit - RATE_CNT_W_L'(1)) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b1;
         end else begin
            cnt_reg  <= cnt_reg + RATE_CNT_W_L'(1);
            tick_reg <= 1'b0;
         end
      end else begin
         tick_reg <= 1'b0;
      end
   end

   assign rif.rate_tick = tick_reg;

   // Checks
   rate_gap_a : assert property (@(posedge clk) disable iff (rif.clear)
      tick_reg |=> !tick_reg [*8])
      else $error("rate ticks too close");
   reserved_code_a : assert property (@(posedge clk)
      (rif.code > 4'h6) |-> (limit == RATE_CNT_W_L'(2 * ccr_pkg::HALF_FS_TICKS)))
      else $error("reserved rate code not mapped to base rate");

endmodule : ccr_rate_div

//--- rtl/ccr_clock_ctrl.sv
// Core clock selection, division, gating and sample rate control.
// Assumes clock pins are slow against clk and a byte register port.
module ccr_clock_ctrl (
   // System
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Pins
   input  wire logic        power_down_pin_n,
   input  wire logic        master_clock_input_pin,
   input  wire logic        pll_clock_pin,
   input  wire logic        pll_lock_pin,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // Clocks and rates
   output logic             core_clk_tick,
   output logic             converter_rate_tick,
   output logic             engine_rate_tick,
   output logic             serial_rate_tick,
   // Power and mode
   output logic      [7:0]  power_enable_a,
   output logic      [7:0]  power_enable_b,
   output logic             adc_on,
   output logic             dac_on,
   output logic             pll_on,
   output logic             adc_osr_64,
   output logic             dac_osr_64,
   output logic             device_active
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic       pdn_ok;
   logic       mclk_lvl;
   logic       pllclk_lvl;
   logic       lock_ok;
   logic       clear;

   // Two flops per pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
      end else begin
         pin_s1 <= {power_down_pin_n, master_clock_input_pin, pll_clock_pin, pll_lock_pin};
         pin_s2 <= pin_s1;
      end
   end

   assign pdn_ok     = pin_s2[3];
   assign mclk_lvl   = pin_s2[2];
   assign pllclk_lvl = pin_s2[1];
   assign lock_ok    = pin_s2[0];
   assign clear      = !rst_n || !pdn_ok;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0] clock_control_reg;
   logic [7:0] converter_control_zero_reg;
   logic [7:0] digital_power_enable_a_reg;
   logic [7:0] digital_power_enable_b_reg;
   logic [7:0] engine_frame_rate_reg;
   logic [7:0] serial_port_rate_reg;
   logic       access_open;
   logic       addr_allowed;
   logic       wr_ok;
   logic       core_en;
   logic       src_pll;

   assign core_en      = clock_control_reg[ccr_pkg::BIT_CORE_EN];
   assign src_pll      = clock_control_reg[ccr_pkg::BIT_SRC_PLL];
   assign access_open  = core_en && lock_ok;
   assign addr_allowed = access_open || reg_addr == ccr_pkg::ADDR_CLOCK_CONTROL
                         || reg_addr == ccr_pkg::ADDR_PLL_CONTROL;
   assign wr_ok        = reg_wr_en && addr_allowed;

   // Clock control, source and divider frozen while the core clock runs
   always_ff @(posedge clk) begin
      if (clear) begin
         clock_control_reg <= ccr_pkg::RESET_BYTE;
      end else if (wr_ok && reg_addr == ccr_pkg::ADDR_CLOCK_CONTROL) begin
         clock_control_reg[ccr_pkg::BIT_CORE_EN] <= reg_wdata[ccr_pkg::BIT_CORE_EN];
         if (!core_en) begin
            clock_control_reg[3:1] <= reg_wdata[3:1];
         end
      end
   end

   // Rate and power registers, reachable only once running and locked
   always_ff @(posedge clk) begin
      if (clear) begin
         converter_control_zero_reg <= ccr_pkg::RESET_BYTE;
         digital_power_enable_a_reg <= ccr_pkg::RESET_BYTE;
         digital_power_enable_b_reg <= ccr_pkg::RESET_BYTE;
         engine_frame_rate_reg      <= ccr_pkg::RESET_BYTE;
         serial_port_rate_reg       <= ccr_pkg::RESET_BYTE;
      end else if (wr_ok) begin
         case (reg_addr)
            ccr_pkg::ADDR_CONVERTER_CTRL0:   converter_control_zero_reg <= reg_wdata;
            ccr_pkg::ADDR_POWER_ENABLE_A:    digital_power_enable_a_reg <= reg_wdata;
            ccr_pkg::ADDR_POWER_ENABLE_B:    digital_power_enable_b_reg <= reg_wdata;
            ccr_pkg::ADDR_ENGINE_FRAME_RATE: engine_frame_rate_reg      <= reg_wdata;
            ccr_pkg::ADDR_SERIAL_PORT_RATE:  serial_port_rate_reg       <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the request
   always_ff @(posedge clk) begin
      if (clear) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd_en;
         reg_rdata  <= 8'h00;
         if (reg_rd_en && addr_allowed) begin
            case (reg_addr)
               ccr_pkg::ADDR_CLOCK_CONTROL:     reg_rdata <= {4'h0, clock_control_reg[3:0]};
               ccr_pkg::ADDR_PLL_CONTROL:       reg_rdata <= {6'h00, lock_ok, 1'b0};
               ccr_pkg::ADDR_CONVERTER_CTRL0:   reg_rdata <= converter_control_zero_reg;
               ccr_pkg::ADDR_POWER_ENABLE_A:    reg_rdata <= digital_power_enable_a_reg;
               ccr_pkg::ADDR_POWER_ENABLE_B:    reg_rdata <= digital_power_enable_b_reg;
               ccr_pkg::ADDR_ENGINE_FRAME_RATE: reg_rdata <= {4'h0, engine_frame_rate_reg[3:0]};
               ccr_pkg::ADDR_SERIAL_PORT_RATE:  reg_rdata <= {5'h00, serial_port_rate_reg[2:0]};
               default:                         reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Core clock divider
   // ----------------------------------------------------------------------
   logic       src_lvl;
   logic       src_d_reg;
   logic       src_rise;
   logic [1:0] div_val;
   logic [1:0] div_cnt_reg;
   logic       tick_reg;

   assign src_lvl  = src_pll ? pllclk_lvl : mclk_lvl;
   assign src_rise = src_lvl && !src_d_reg;
   assign div_val  = src_pll ? ccr_pkg::DIV_BY_FOUR
                             : clock_control_reg[ccr_pkg::BIT_RATE_HI:ccr_pkg::BIT_RATE_LO];

   // Divide source edges down to 256 x base rate, gated by enable
   always_ff @(posedge clk) begin
      if (clear) begin
         src_d_reg   <= 1'b0;
         div_cnt_reg <= 2'h0;
         tick_reg    <= 1'b0;
      end else begin
         src_d_reg <= src_lvl;
         tick_reg  <= 1'b0;
         if (!core_en) begin
            div_cnt_reg <= 2'h0;
         end else if (src_rise) begin
            if (div_cnt_reg >= div_val) begin
               div_cnt_reg <= 2'h0;
               tick_reg    <= 1'b1;
            end else begin
               div_cnt_reg <= div_cnt_reg + 2'h1;
            end
         end
      end
   end

   assign core_clk_tick = tick_reg;

   // ----------------------------------------------------------------------
   // Sample rate dividers, all fed by the core tick
   // ----------------------------------------------------------------------
   ccr_rate_if rate_link [3] ();
   logic [3:0] rate_code [3];
   logic [2:0] rate_tick_q;

   assign rate_code[0] = {1'b0, converter_control_zero_reg[2:0]};
   assign rate_code[1] = engine_frame_rate_reg[3:0];
   assign rate_code[2] = {1'b0, serial_port_rate_reg[2:0]};

   for (genvar g = 0; g < 3; g++) begin : g_rate
      assign rate_link[g].clear     = clear || !core_en;
      assign rate_link[g].core_tick = tick_reg;
      assign rate_link[g].code      = rate_code[g];
      assign rate_tick_q[g]         = rate_link[g].rate_tick;
      ccr_rate_div u_div (
         .clk (clk),
         .rif (rate_link[g])
      );
   end

   assign converter_rate_tick = rate_tick_q[0];
   assign engine_rate_tick    = rate_tick_q[1];
   assign serial_rate_tick    = rate_tick_q[2];

   // ----------------------------------------------------------------------
   // Power and mode outputs
   // ----------------------------------------------------------------------
   // Converters and power enables run only when enabled and the core clock runs; PLL runs until its power bit is set
   always_ff @(posedge clk) begin
      if (clear) begin
         power_enable_a <= 8'h00;
         power_enable_b <= 8'h00;
         adc_on         <= 1'b0;
         dac_on         <= 1'b0;
         pll_on         <= 1'b0;
         adc_osr_64     <= 1'b0;
         dac_osr_64     <= 1'b0;
         device_active  <= 1'b0;
      end else begin
         power_enable_a <= core_en ? digital_power_enable_a_reg : 8'h00;
         power_enable_b <= core_en ? digital_power_enable_b_reg : 8'h00;
         adc_on  <= core_en && digital_power_enable_b_reg[ccr_pkg::BIT_ADC_PWR];
         dac_on  <= core_en && digital_power_enable_b_reg[ccr_pkg::BIT_DAC_PWR];
         pll_on  <= !digital_power_enable_b_reg[ccr_pkg::BIT_PLL_PWR];
         adc_osr_64 <= converter_control_zero_reg[ccr_pkg::BIT_ADC_OSR64];
         dac_osr_64 <= converter_control_zero_reg[ccr_pkg::BIT_DAC_OSR64];
         // Running once the core clock runs locked and the memory controller and engine are enabled
         device_active <= access_open
                          && digital_power_enable_a_reg[ccr_pkg::BIT_MEM_CTRL]
                          && digital_power_enable_a_reg[ccr_pkg::BIT_ENGINE];
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   pll_divide_a : assert property (src_pll |-> div_val == 2'h3)
      else $error("PLL source not divided by four");
   core_gate_a : assert property (!core_en |=> !core_clk_tick)
      else $error("core tick while gated");
   pin_clear_a : assert property (!pdn_ok |=> clock_control_reg == 8'h00
      && digital_power_enable_a_reg == 8'h00 ##1 !adc_osr_64 && !device_active)
      else $error("power-down pin did not clear state");
   locked_write_a : assert property (reg_wr_en && !addr_allowed |=>
      $stable(digital_power_enable_a_reg) && $stable(converter_control_zero_reg))
      else $error("write taken before lock");
   source_hold_a : assert property (core_en && !clear |=> $stable(clock_control_reg[3:1]))
      else $error("source or divider changed while running");
   adc_power_a : assert property (adc_on |-> $past(core_en)
      && $past(digital_power_enable_b_reg[ccr_pkg::BIT_ADC_PWR]))
      else $error("converter powered without enable");
   tick_spacing_a : assert property (core_clk_tick && src_pll |=> !core_clk_tick [*7])
      else $error("core tick faster than source over four");
   rate_from_core_a : assert property (converter_rate_tick |-> $past(core_clk_tick))
      else $error("rate tick not from core tick");
   div_range_a : assert property (core_en |-> div_cnt_reg <= div_val)
      else $error("core divider count beyond its setting");

   // Register port, power and mode checks
   read_refused_a : assert property (reg_rd_en && !addr_allowed && !clear |=>
      reg_rvalid && reg_rdata == 8'h00)
      else $error("refused read returned data");
   power_gate_a : assert property (!core_en |=> power_enable_a == 8'h00
      && power_enable_b == 8'h00)
      else $error("subsystem enabled while core clock off");
   dac_power_a : assert property (dac_on |-> $past(core_en)
      && $past(digital_power_enable_b_reg[ccr_pkg::BIT_DAC_PWR]))
      else $error("converter powered without enable");
   pll_power_a : assert property (digital_power_enable_b_reg[ccr_pkg::BIT_PLL_PWR]
      && !clear |=> !pll_on)
      else $error("PLL left on after power-off");
   adc_osr_a : assert property (adc_osr_64 |->
      $past(converter_control_zero_reg[ccr_pkg::BIT_ADC_OSR64]))
      else $error("low oversampling without request");
   dac_osr_a : assert property (dac_osr_64 |->
      $past(converter_control_zero_reg[ccr_pkg::BIT_DAC_OSR64]))
      else $error("low oversampling without request");

endmodule : ccr_clock_ctrl

//--- sim/core_clock_and_rate_control_bench.sv
// Self-checking bench for the core clock and rate control block.
// Assumes the ccr_pkg package is compiled first; drives all pins itself.
module core_clock_and_rate_control_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        pdn_n = 1'b1;
   logic        mck = 1'b0;
   logic        pck = 1'b0;
   logic        lock = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        rvalid;
   logic [3:0]  tk;
   logic [7:0]  pwr_a;
   logic [7:0]  pwr_b;
   logic        adc_on;
   logic        dac_on;
   logic        pll_on;
   logic        adc_osr;
   logic        dac_osr;
   logic        active;
   logic        clr_mon = 1'b1;
   logic [1:0]  ph = 2'h0;
   int          ivl [4];
   int          age [4];
   int          ntk [4];
   int          n_fail = 0;
   int          n_tests = 0;

   ccr_clock_ctrl i_dut (
      .clk(clk), .rst_n(rst_n), .power_down_pin_n(pdn_n),
      .master_clock_input_pin(mck), .pll_clock_pin(pck), .pll_lock_pin(lock),
      .reg_addr(addr), .reg_wr_en(wr), .reg_rd_en(rd), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_rvalid(rvalid),
      .core_clk_tick(tk[3]), .converter_rate_tick(tk[0]),
      .engine_rate_tick(tk[1]), .serial_rate_tick(tk[2]),
      .power_enable_a(pwr_a), .power_enable_b(pwr_b), .adc_on(adc_on),
      .dac_on(dac_on), .pll_on(pll_on), .adc_osr_64(adc_osr),
      .dac_osr_64(dac_osr), .device_active(active));

   // Clock, master pin every cycle, PLL pin every second cycle
   always #25 clk = ~clk;
   always @(negedge clk) begin
      mck <= ~mck;
      ph  <= ph + 2'h1;
      if (ph[0]) pck <= ~pck;
   end

   // Measures the spacing of each tick output in system cycles
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (clr_mon) begin
            age[i] = 0; ntk[i] = 0; ivl[i] = 0;
         end else begin
            age[i]++;
            if (tk[i] === 1'b1) begin
               ivl[i] = age[i]; age[i] = 0; ntk[i]++;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Compare and bus tasks
   // ---------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1

   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a; wdata = d; wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg

   // PLL control bytes sent as one unbroken write burst
   task automatic wr_pll_burst(input logic [47:0] d);
      @(negedge clk);
      for (int b = 0; b < 6; b++) begin
         addr  = 16'h4002;
         wdata = d[8 * (5 - b) +: 8];
         wr    = 1'b1;
         @(negedge clk);
      end
      wr = 1'b0;
   endtask : wr_pll_burst

   // Read strobe, then sample the answer in the one cycle it stands
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a; rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk1(rvalid, 1'b1);
      chk8(rdata, exp);
      @(negedge clk);
      chk1(rvalid, 1'b0);
   endtask : rd_reg

   task automatic end_sim;
      $display("tests=%0d failures=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   // Rate scaling in half units of the base period
   function automatic int half_units(input logic [3:0] c);
      case (c)
         4'h1: return 12;
         4'h2: return 8;
         4'h3: return 6;
         4'h4: return 4;
         4'h5: return 3;
         4'h6: return 1;
         default: return 2;
      endcase
   endfunction : half_units

   // Core period in system cycles for a clock control value
   function automatic int core_period(input logic [7:0] cc);
      if (cc[3]) return 4 * 4;
      return (int'(cc[2:1]) + 1) * 2;
   endfunction : core_period

   // Program clocking and rates, then measure every tick spacing
   task automatic run_cfg(input logic [7:0] cc, input logic [3:0] cv,
                          input logic [3:0] ev, input logic [3:0] sv);
      int n;
      int cp;
      n  = 0;
      cp = core_period(cc);
      wr_reg(16'h4000, 8'h00);
      wr_reg(16'h4000, cc & 8'hfe);
      wr_reg(16'h4000, cc | 8'h01);
      wr_reg(16'h4017, {5'h00, cv[2:0]});
      wr_reg(16'h40eb, {4'h0, ev});
      wr_reg(16'h40f8, {5'h00, sv[2:0]});
      @(negedge clk) clr_mon = 1'b1;
      @(negedge clk) clr_mon = 1'b0;
      while ((ntk[0] < 3 || ntk[1] < 3 || ntk[2] < 3 || ntk[3] < 3) && n < 40000) begin
         @(negedge clk);
         n++;
      end
      chk_cnt(ivl[3], cp);
      chk_cnt(ivl[0], half_units(cv) * 128 * cp);
      chk_cnt(ivl[1], half_units(ev) * 128 * cp);
      chk_cnt(ivl[2], half_units(sv) * 128 * cp);
      rd_reg(16'h4000, cc | 8'h01);
   endtask : run_cfg

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] v;
      void'($urandom(32'hc8b778c8));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk1(pll_on, 1'b1);
      chk1(active, 1'b0);
      chk1(adc_osr, 1'b0);
      // Enabled but not locked: other registers stay out of reach
      wr_reg(16'h4000, 8'h01);
      wr_reg(16'h4080, 8'h41);
      repeat (3) @(negedge clk);
      chk8(pwr_a, 8'h00);
      rd_reg(16'h4080, 8'h00);
      wr_pll_burst({16'($urandom), $urandom});
      rd_reg(16'h4002, 8'h00);
      lock = 1'b1;
      repeat (4) @(negedge clk);
      rd_reg(16'h4002, 8'h02);
      rd_reg(16'h4080, 8'h00);
      rd_reg(16'h4081, 8'h00);
      rd_reg(16'h4017, 8'h00);
      rd_reg(16'h40eb, 8'h00);
      rd_reg(16'h40f8, 8'h00);
      rd_reg(16'h4001, 8'h00);
      chk1(active, 1'b0);
      wr_reg(16'h4080, 8'h41);
      repeat (3) @(negedge clk);
      chk8(pwr_a, 8'h41);
      chk1(active, 1'b1);
      v = 8'($urandom_range(0, 7));
      wr_reg(16'h4081, v);
      repeat (3) @(negedge clk);
      chk1(adc_on, v[0]);
      chk1(dac_on, v[1]);
      chk1(pll_on, ~v[2]);
      chk8(pwr_b, v);
      wr_reg(16'h4017, 8'h18);
      repeat (3) @(negedge clk);
      chk1(adc_osr, 1'b1);
      chk1(dac_osr, 1'b1);
      // Every rate code on converter and serial fields, engine codes 0 to 6 then one upper code at random
      for (int i = 0; i < 8; i++) begin
         v = (i == 7) ? 8'(8 + $urandom_range(0, 7)) : 8'(i);
         run_cfg(8'h00, 4'(i), v[3:0], 4'(7 - i));
      end
      // Every divider code on the master pin, then PLL forcing divide by four
      for (int d = 0; d < 4; d++) run_cfg({5'h00, 2'(d), 1'b0}, 4'h6, 4'h6, 4'h6);
      run_cfg(8'h08, 4'h6, 4'h6, 4'h6);
      wr_reg(16'h4000, 8'h07);
      rd_reg(16'h4000, 8'h09);
      // Power-down pin wipes all state
      @(negedge clk) pdn_n = 1'b0;
      repeat (5) @(negedge clk);
      pdn_n = 1'b1;
      repeat (4) @(negedge clk);
      chk1(active, 1'b0);
      chk8(pwr_a, 8'h00);
      rd_reg(16'h4000, 8'h00);
      end_sim();
   end

   // Watchdog: the tests need about 60000 cycles, so this leaves ample margin
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      end_sim();
   end
endmodule : core_clock_and_rate_control_bench
